/* rtl/dg_pkg.sv */
// Shared constants and types for the DRAM data core
package dg_pkg;
  localparam int BEATS_PER_CLK   = 2;
  localparam int CORE_CLKS       = 4;
  localparam int BURST_BEATS     = BEATS_PER_CLK * CORE_CLKS;
  localparam int BANKS_PER_GROUP = 4;
  localparam int GROUPS_X8       = 4;
  localparam int GROUPS_X16      = 2;
  localparam int BYTE_W          = 8;
  localparam int FIFO_DEPTH      = 8;
  localparam int COLS_DEF        = 4;
  localparam int BEAT_CNT_W      = 4;
  localparam logic [BEAT_CNT_W-1:0] BEAT_LAST = 4'h7;
  localparam logic [BEAT_CNT_W-1:0] BEAT_DONE = 4'h8;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  typedef enum logic [1:0] {DG_IDLE, DG_WRITE, DG_READ} dg_mode_t;
endpackage

/* rtl/dg_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dg_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             count;
  } dg_fifo_st_t;
  dg_fifo_st_t s_q, s_d;
  logic push, pop;

  assign in_ready  = s_q.count != (AW+1)'(DEPTH);
  assign out_valid = s_q.count != '0;
  assign out_data  = s_q.mem[s_q.rptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wptr] = in_data;
      s_d.wptr          = (s_q.wptr == AW'(DEPTH-1)) ? '0 : s_q.wptr + 1'b1;
    end
    if (pop) begin
      s_d.rptr = (s_q.rptr == AW'(DEPTH-1)) ? '0 : s_q.rptr + 1'b1;
    end
    s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* rtl/dg_core.sv */
// DRAM data core: double-rate pins, eight-beat bursts, banked block store
`timescale 1ns/1ps
module dg_core
  import dg_pkg::*;
#(
  parameter bit X16  = 1'b1,
  parameter int COLS = dg_pkg::COLS_DEF,
  parameter int DQ_W = X16 ? 2 * dg_pkg::BYTE_W : dg_pkg::BYTE_W,
  parameter int COL_W = $clog2(COLS)
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // Link clock and command pins
  input  wire logic             ck_pin,
  input  wire logic             cs_n_pin,
  input  wire logic [2:0]       cmd_pin,
  input  wire logic [1:0]       bg_pin,
  input  wire logic [1:0]       ba_pin,
  input  wire logic [COL_W-1:0] col_pin,
  // Data pins
  input  wire logic [DQ_W-1:0]  dq_i,
  output logic [DQ_W-1:0]       dq_o,
  output logic                  dq_oe,
  output logic                  term_en,
  // Mode and core control
  input  wire logic             odt_enable,
  input  wire logic             dll_enable,
  input  wire logic             core_hold,
  // Status
  output logic                  wr_ready,
  output logic                  overflow,
  output logic                  cmd_refused,
  output logic                  timing_valid
);
  import dg_pkg::*;

  // Geometry follows the lane width
  localparam int NBANK = BANKS_PER_GROUP * (X16 ? GROUPS_X16 : GROUPS_X8);
  localparam int NBLK  = NBANK * COLS;
  localparam int AW    = $clog2(NBLK);
  localparam int BLK_W = BURST_BEATS * DQ_W;
  localparam int PIN_W = 1 + 1 + 3 + 2 + 2 + COL_W + DQ_W;

  // All state but the FIFO's, block store included, lives in one register
  typedef struct packed {
    logic [PIN_W-1:0]                    sync1;
    logic [PIN_W-1:0]                    sync2;
    logic                                ck_last;
    dg_mode_t                            mode;
    logic [BEAT_CNT_W-1:0]               beat;
    logic [BURST_BEATS-1:0][DQ_W-1:0]    rd_blk;
    logic [AW-1:0]                       wr_addr;
    logic [BURST_BEATS-1:0][DQ_W-1:0]    acc;
    logic [BEAT_CNT_W-1:0]               acc_cnt;
    logic [NBLK-1:0][BLK_W-1:0]          mem;
    logic [DQ_W-1:0]                     dq_o;
    logic                                dq_oe;
    logic                                term;
    logic                                ovf;
    logic                                refused;
    logic                                tvalid;
  } dg_core_st_t;

  dg_core_st_t s_q, s_d;

  // Bank and column to block index
  function automatic logic [AW-1:0] blk_index(input logic [1:0]       bg,
                                              input logic [1:0]       ba,
                                              input logic [COL_W-1:0] col);
    logic [3:0] bank;
    bank = X16 ? {1'b0, bg[0], ba} : {bg, ba};
    return AW'(int'(bank) * COLS + int'(col));
  endfunction

  logic                  ck_s;
  logic                  cs_n_s;
  logic [2:0]            cmd_s;
  logic [1:0]            bg_s;
  logic [1:0]            ba_s;
  logic [COL_W-1:0]      col_s;
  logic [DQ_W-1:0]       dq_s;
  logic                  edge_any;
  logic                  edge_rise;
  logic                  push;
  logic                  f_in_ready;
  logic                  f_out_valid;
  logic                  pop;
  logic [DQ_W-1:0]       f_out_data;
  logic                  drain_busy;

  // One sampling word keeps each beat aligned with its link edge
  assign {ck_s, cs_n_s, cmd_s, bg_s, ba_s, col_s, dq_s} = s_q.sync2;
  // Both link edges carry a beat
  assign edge_any   = ck_s != s_q.ck_last;
  assign edge_rise  = ck_s & ~s_q.ck_last;
  assign push       = edge_any & (s_q.mode == DG_WRITE);
  assign pop        = f_out_valid & ~core_hold;
  assign drain_busy = f_out_valid | (s_q.acc_cnt != '0);

  // Pin beats wait here while the core is held off
  dg_fifo #(
    .W     (DQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (dq_s),
    .out_valid (f_out_valid),
    .out_ready (~core_hold),
    .out_data  (f_out_data)
  );

  always_comb begin
    s_d         = s_q;
    s_d.sync1   = {ck_pin, cs_n_pin, cmd_pin, bg_pin, ba_pin, col_pin, dq_i};
    s_d.sync2   = s_q.sync1;
    s_d.ck_last = ck_s;
    s_d.refused = 1'b0;
    // Status mirrors the loop mode a cycle later
    s_d.tvalid  = dll_enable;
    // Sticky until reset, since a lost beat cannot be recovered
    if (push && !f_in_ready) begin
      s_d.ovf = 1'b1;
    end
    unique case (s_q.mode)
      DG_IDLE: begin
        // Deselect and no-operation both leave the core idle
        if (edge_rise && !cs_n_s && cmd_s != CMD_NOP) begin
          // A block still draining would be overwritten, so refuse the command until it lands
          if (drain_busy) begin
            s_d.refused = 1'b1;
          end else begin
            unique case (cmd_s)
              CMD_WR: begin
                s_d.mode    = DG_WRITE;
                s_d.beat    = '0;
                s_d.wr_addr = blk_index(bg_s, ba_s, col_s);
              end
              CMD_RD: begin
                s_d.mode   = DG_READ;
                s_d.beat   = '0;
                s_d.rd_blk = s_q.mem[blk_index(bg_s, ba_s, col_s)];
              end
              // Unknown codes are refused rather than guessed at
              default: begin
                s_d.refused = 1'b1;
              end
            endcase
          end
        end
      end
      DG_WRITE: begin
        // Beats go to the FIFO; here only the edges are counted
        if (edge_any) begin
          s_d.beat = s_q.beat + 1'b1;
          if (s_q.beat == BEAT_LAST) begin
            s_d.mode = DG_IDLE;
          end
        end
      end
      DG_READ: begin
        if (edge_any) begin
          // The edge after the eighth beat releases the lane
          if (s_q.beat == BEAT_DONE) begin
            s_d.dq_oe = 1'b0;
            s_d.mode  = DG_IDLE;
          end else begin
            s_d.dq_o  = s_q.rd_blk[s_q.beat[2:0]];
            s_d.dq_oe = 1'b1;
            s_d.beat  = s_q.beat + 1'b1;
          end
        end
      end
    endcase
    // Eight beats gather into one core block
    if (pop) begin
      s_d.acc[s_q.acc_cnt[2:0]] = f_out_data;
      if (s_q.acc_cnt == BEAT_LAST) begin
        s_d.acc_cnt          = '0;
        s_d.mem[s_q.wr_addr] = s_d.acc;
      end else begin
        s_d.acc_cnt = s_q.acc_cnt + 1'b1;
      end
    end
    // Idle pins terminate only when the mode asks for it
    s_d.term = odt_enable & ~s_d.dq_oe;
  end

  // Memory clears with the rest of the state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end


  // Outputs come straight from state flops, except wr_ready, decoded from the FIFO count
  assign dq_o         = s_q.dq_o;
  assign dq_oe        = s_q.dq_oe;
  assign term_en      = s_q.term;
  assign wr_ready     = f_in_ready;
  assign overflow     = s_q.ovf;
  assign cmd_refused  = s_q.refused;
  assign timing_valid = s_q.tvalid;
endmodule

/* tb/dg_core_monitor.sv */
// Pin-level property checker for the DRAM data core
`timescale 1ns/1ps
module dg_core_monitor #(parameter int DQ_W = 16) (
  // Clock and reset
  input wire logic            core_clk,
  input wire logic            arst_n,
  // Link pins
  input wire logic            ck_pin,
  input wire logic            cs_n_pin,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic            dq_oe,
  input wire logic            term_en,
  // Mode and status
  input wire logic            odt_enable,
  input wire logic            dll_enable,
  input wire logic            cmd_refused,
  input wire logic            timing_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic       ck_q;
  logic [4:0] tog_q;
  // Counts raw link edges seen while driving
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_q  <= 1'b0;
      tog_q <= 5'h0;
    end else begin
      ck_q  <= ck_pin;
      tog_q <= dq_oe ? tog_q + 5'(ck_pin != ck_q) : 5'h0;
    end
  end
  sequence ck_quiet;
    $stable(ck_pin) [*5];
  endsequence
  sequence drive_run;
    dq_oe [*5];
  endsequence
  chk_beat_hold: assert property ((ck_quiet and drive_run) |-> $stable(dq_o))
    else $error("read beat moved between link edges");
  chk_beat_count: assert property ($fell(dq_oe) |-> tog_q == 5'h8)
    else $error("read burst not eight beats long");
  chk_term_drive: assert property (dq_oe && $past(dq_oe) |-> !term_en)
    else $error("termination on while driving");
  chk_term_idle: assert property (!dq_oe && !$past(dq_oe) && $past(odt_enable)
    && $past(arst_n) |-> term_en)
    else $error("termination off while idle");
  chk_dll_on: assert property (dll_enable [*2] |-> timing_valid)
    else $error("timing status missing with loop on");
  chk_dll_drop: assert property ($fell(dll_enable) |=> !timing_valid)
    else $error("timing status kept with loop off");
  chk_refuse_pulse: assert property (cmd_refused |=> !cmd_refused)
    else $error("refusal longer than one cycle");
  chk_refuse_sel: assert property (cmd_refused |-> !$past(cs_n_pin, 3))
    else $error("refusal without a selected command");
endmodule
bind dg_core dg_core_monitor #(.DQ_W(DQ_W)) mon_u (.core_clk(core_clk), .arst_n(arst_n),
  .ck_pin(ck_pin), .cs_n_pin(cs_n_pin), .dq_o(dq_o), .dq_oe(dq_oe), .term_en(term_en),
  .odt_enable(odt_enable), .dll_enable(dll_enable), .cmd_refused(cmd_refused),
  .timing_valid(timing_valid));

/* tb/dg_ctrl_model.sv */
// Controller-side model: link clock, command pins and write beats
`timescale 1ns/1ps
module dg_ctrl_model (
  // Link clock and command
  output logic        ck_pin,
  output logic        cs_n_pin,
  output logic [2:0]  cmd_pin,
  output logic [1:0]  bg_pin,
  output logic [1:0]  ba_pin,
  output logic [1:0]  col_pin,
  // Write data
  output logic [15:0] dq_i
);
  initial begin
    ck_pin = 1'b0;
    cs_n_pin = 1'b1;
    {cmd_pin, bg_pin, ba_pin, col_pin} = 9'h0;
    dq_i = 16'h0;
  end
  // Grade codes and a shortened base refresh interval for the model
  localparam int industrial_grade    = 0;
  localparam int automotive_grade    = 1;
  localparam int extended_heat_grade = 2;
  localparam int GRADE               = automotive_grade;
  localparam int REFI_NS             = 800;
  // Refresh rate multiple for a grade at a case temperature
  function automatic int rate_factor(input int grade, input int temp_c);
    int f;
    f = 1;
    if (temp_c > 85) f = 2;
    if (grade != industrial_grade && temp_c > 95) f = 4;
    if (grade == extended_heat_grade && temp_c > 105) f = 8;
    return f;
  endfunction
  // Link rests deselected for one scaled refresh interval
  task automatic refresh_gap(input int temp_c);
    #(REFI_NS / rate_factor(GRADE, temp_c));
  endtask
  // Clock stands low between frames; released pins show inverted values
  task automatic burst(input logic [2:0] code, input logic [2:0] bank,
                       input logic [1:0] col, input logic [127:0] blk);
    #1;
    cs_n_pin = 1'b0;
    cmd_pin = code;
    {bg_pin, ba_pin} = {1'b0, bank};
    col_pin = col;
    #80 ck_pin = 1'b1;
    // Nine edges follow the command edge, so the clock comes to rest low
    for (int k = 0; k < 9; k++) begin
      #40;
      if (k == 0) cs_n_pin = 1'b1;
      if (k == 0) {cmd_pin, bg_pin, ba_pin, col_pin} = ~{cmd_pin, bg_pin, ba_pin, col_pin};
      dq_i = (k < 8) ? blk[k*16 +: 16] : ~dq_i;
      #40 ck_pin = ~ck_pin;
    end
  endtask
endmodule

/* tb/ddr4_general_operating_rules_test.sv */
// Self-checking bench for the DRAM data core
`timescale 1ns/1ps
module ddr4_general_operating_rules_test;
  import dg_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, odt_enable = 1'b0, dll_enable = 1'b0, core_hold = 1'b0;
  logic ck_pin, cs_n_pin, dq_oe, term_en, wr_ready, overflow, cmd_refused, timing_valid;
  logic [2:0]   cmd_pin, b;
  logic [1:0]   bg_pin, ba_pin, col_pin, c;
  logic [15:0]  dq_i, dq_o;
  logic [127:0] mem [32] = '{default: 128'h0};
  logic [15:0]  exp_q [$];
  logic         half_lane = 1'b0;
  int err_count = 0, n_tests = 0, seed = 44175, ref_seen = 0, ref_exp = 0;
  always #5 core_clk = ~core_clk;
  dg_core dut_u (.core_clk(core_clk), .arst_n(arst_n), .ck_pin(ck_pin), .cs_n_pin(cs_n_pin),
    .cmd_pin(cmd_pin), .bg_pin(bg_pin), .ba_pin(ba_pin), .col_pin(col_pin), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe), .term_en(term_en), .odt_enable(odt_enable),
    .dll_enable(dll_enable), .core_hold(core_hold), .wr_ready(wr_ready), .overflow(overflow),
    .cmd_refused(cmd_refused), .timing_valid(timing_valid));
  dg_ctrl_model ctl_u (.ck_pin(ck_pin), .cs_n_pin(cs_n_pin), .cmd_pin(cmd_pin),
    .bg_pin(bg_pin), .ba_pin(ba_pin), .col_pin(col_pin), .dq_i(dq_i));
  task automatic check(input string what, input logic [127:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Beat k stands until link edge k+1, so sample just before it moves
  always @(ck_pin) if (dq_oe === 1'b1) begin
    check("read beat", dq_o, exp_q.size() ? exp_q.pop_front() : 'x);
  end
  always @(posedge core_clk) if (cmd_refused === 1'b1) ref_seen++;
  task automatic op(input logic [2:0] code, input logic [2:0] bank, input logic [1:0] col);
    logic [127:0] blk;
    blk = {$random(seed), $random(seed), $random(seed), $random(seed)};
    if (half_lane) for (int k = 0; k < 8; k++) blk[k*16+8 +: 8] = 8'hff;
    if (code == CMD_WR) mem[{bank, col}] = blk;
    if (code == CMD_RD) for (int k = 0; k < 8; k++) exp_q.push_back(mem[{bank, col}][k*16 +: 16]);
    ctl_u.burst(code, bank, col, blk);
    repeat (20) @(posedge core_clk);
  endtask
  // Roughly 25 bursts of about 100 cycles each, with ample margin
  initial begin
    #100us;
    err_count++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 arst_n = 1'b1;
    odt_enable = 1'b1;
    dll_enable = 1'b1;
    repeat (3) @(posedge core_clk);
    check("idle termination", term_en, 1'b1);
    check("timing status", timing_valid, 1'b1);
    op(CMD_RD, 3'h5, 2'h2);
    for (int i = 0; i < 6; i++) begin
      b = 3'($random(seed));
      c = 2'($random(seed));
      op(CMD_WR, b, c);
      op(CMD_RD, b, c);
    end
    ctl_u.refresh_gap(100);
    half_lane = 1'b1;
    op(CMD_WR, 3'h6, 2'h1);
    op(CMD_RD, 3'h6, 2'h1);
    half_lane = 1'b0;
    op(CMD_NOP, 3'h0, 2'h0);
    for (int k = 0; k < 8; k++) if (!(k inside {4, 5, 7})) begin
      op(3'(k), 3'h7, 2'h1);
      ref_exp++;
    end
    core_hold <= 1'b1;
    op(CMD_WR, 3'h1, 2'h3);
    check("fifo full", wr_ready, 1'b0);
    ctl_u.burst(CMD_WR, 3'h2, 2'h0, '1);
    ref_exp++;
    @(posedge core_clk) #1 core_hold = 1'b0;
    repeat (20) @(posedge core_clk);
    op(CMD_RD, 3'h1, 2'h3);
    op(CMD_RD, 3'h2, 2'h0);
    @(posedge core_clk) #1 dll_enable = 1'b0;
    repeat (2) @(posedge core_clk);
    check("timing status off", timing_valid, 1'b0);
    check("refusals", ref_seen, ref_exp);
    check("overflow", overflow, 1'b0);
    check("beats left", exp_q.size(), 0);
    conclude();
  end
endmodule
